/* File: include/cctmr_defines.vh */
`ifndef CCTMR_DEFINES_VH
`define CCTMR_DEFINES_VH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define CCTMR_ADR_CNT_HIGH 6'h00
`define CCTMR_ADR_CNT_LOW 6'h04
`define CCTMR_ADR_RLD_HIGH 6'h08
`define CCTMR_ADR_RLD_LOW 6'h0C
`define CCTMR_ADR_CAP_HIGH 6'h10
`define CCTMR_ADR_CAP_LOW 6'h14
`define CCTMR_ADR_CONTROL 6'h18
`define CCTMR_ADR_STATUS 6'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CCTMR_CTL_ENABLE 7
`define CCTMR_CTL_MODE 6
`define CCTMR_CTL_POLARITY 5
`define CCTMR_CTL_OUT_INIT 4
`define CCTMR_CTL_PRESC_HI 2
`define CCTMR_CTL_PRESC_LO 0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CCTMR_STS_EVENT 0
`define CCTMR_STS_CAPTURED 1
`define CCTMR_STS_RUNNING 2

// ----------------------------------------
// Reset and restart values
// ----------------------------------------
`define CCTMR_RESTART_COUNT 16'h0001
`define CCTMR_RST_COUNT 16'h0001
`define CCTMR_RST_RELOAD 16'hFFFF
`define CCTMR_RST_CAPTURE 16'h0000
`define CCTMR_RST_CONTROL 8'h00

`endif

/* File: verification/cctmr_edge_src.sv */
`timescale 1ns/100ps
// ----------------
// Timer input source
// ----------------
module cctmr_edge_src (
    input wire clk,
    output reg pin
);
    initial pin = 1'h0;
    // Level changes just after an edge and then holds
    task move(input logic lvl);
        @(posedge clk) pin <= lvl;
    endtask
endmodule

/* File: verification/cctmr_props.sv */
`timescale 1ns/100ps
// ----------------
// Port checker
// ----------------
module cctmr_props (
    input wire CLOCK,
    input wire RESET,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [5:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire TIMER_IN,
    input wire TIMER_OUT,
    input wire TIMER_EVENT
);
    reg en_q, mode_q, pol_q, prev_q, run_q;
    wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire act = (TIMER_IN != prev_q) && (TIMER_IN != pol_q);
    wire cc = en_q && mode_q;
    // Mirror of the control bits, so edge checks follow software setup
    always @(posedge CLOCK) begin
        prev_q <= TIMER_IN;
        run_q <= cc && (run_q || act) && !RESET;
        if (RESET)
            {en_q, mode_q, pol_q} <= 3'h0;
        else if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 6'h18)
            {en_q, mode_q, pol_q} <= WB_DAT_I[7:5];
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    property p_ack; req |=> WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ackp; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ackp: assert property (p_ackp) else $error("ack too long");
    property p_hi0; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
    a_hi0: assert property (p_hi0) else $error("upper data bits set");
    property p_unm; req && !WB_WE_I && WB_ADR_I > 6'h1C |=> WB_DAT_O == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_tog; TIMER_EVENT |-> TIMER_OUT != $past(TIMER_OUT); endproperty
    a_tog: assert property (p_tog) else $error("output did not toggle");
    property p_off; !en_q && !$past(en_q) |-> !TIMER_EVENT; endproperty
    a_off: assert property (p_off) else $error("event while disabled");
    property p_first; cc && !run_q && act |=> !TIMER_EVENT [*3]; endproperty
    a_first: assert property (p_first) else $error("event on start edge");
    property p_cap; cc && run_q && act |-> ##[1:3] TIMER_EVENT; endproperty
    a_cap: assert property (p_cap) else $error("no event on capture");
endmodule

bind cctmr_top cctmr_props i_props (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TIMER_IN(TIMER_IN),
    .TIMER_OUT(TIMER_OUT), .TIMER_EVENT(TIMER_EVENT));

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    reg clk, rst, cyc, stb, we;
    reg [3:0] sel;
    reg [5:0] adr;
    reg [31:0] wdat;
    wire [31:0] rdat;
    wire ack, tin, tout, tev;
    integer fails, total_checks, ev_n, tg_n, e0, t0, p, k;
    reg [7:0] b, c;
    reg [15:0] v, w;
    reg tq;
    cctmr_top i_dut (.CLOCK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .TIMER_IN(tin), .TIMER_OUT(tout), .TIMER_EVENT(tev));
    cctmr_edge_src i_src (.clk(clk), .pin(tin));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tq <= tout;
        if (tev === 1'h1) ev_n <= ev_n + 1;
        if (tout !== tq) tg_n <= tg_n + 1;
    end
    task chk(input [15:0] got, input [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input w_en, input [5:0] a, input [7:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w_en;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'h1);
        b = rdat[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task rd16(input [5:0] a);
        bus(1'h0, a, 8'h0);
        v[15:8] = b;
        bus(1'h0, a + 6'h4, 8'h0);
        v[7:0] = b;
    endtask
    task wr16(input [5:0] a, input [15:0] d);
        bus(1'h1, a, d[15:8]);
        bus(1'h1, a + 6'h4, d[7:0]);
    endtask
    task finish_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails = fails + 1;
        finish_test;
    end
    // ----------------
    // Test sequence
    // ----------------
    initial begin
        {rst, cyc, stb, we} = 4'h8;
        {sel, adr, wdat} = {4'hF, 38'h0};
        {fails, total_checks, ev_n, tg_n} = 128'h0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rd16(6'h00);
        chk(v, 16'h0001);
        rd16(6'h08);
        chk(v, 16'hFFFF);
        bus(1'h1, 6'h20, 8'h5A);
        bus(1'h0, 6'h20, 8'h0);
        chk(b, 16'h0);
        bus(1'h0, 6'h18, 8'h0);
        chk(b, 16'h0);
        // Rising edge at divide 1, then falling edge at divide 4
        for (p = 0; p < 2; p = p + 1) begin
            c = p ? 8'h62 : 8'h40;
            bus(1'h1, 6'h18, c);
            i_src.move(p == 0);
            wr16(6'h00, 16'h0001);
            wr16(6'h08, 16'hFFFF);
            bus(1'h1, 6'h18, c | 8'h80);
            i_src.move(p != 0);
            repeat (4) @(posedge clk);
            {e0, t0} = {ev_n, tg_n};
            rd16(6'h00);
            chk(v, 16'h0001);
            i_src.move(p == 0);
            i_src.move(p != 0);
            repeat (p ? 158 : 38) @(posedge clk);
            chk(ev_n - e0, 16'h0);
            i_src.move(p == 0);
            repeat (4) @(posedge clk);
            chk(ev_n - e0, 16'h1);
            chk(tg_n - t0, 16'h1);
            // Status: event and capture flags set, still running; then clear both
            bus(1'h0, 6'h1C, 8'h0);
            chk(b, 16'h07);
            bus(1'h1, 6'h1C, 8'h03);
            bus(1'h0, 6'h1C, 8'h0);
            chk(b, 16'h04);
            rd16(6'h00);
            chk(v < 16'h14, 16'h1);
            rd16(6'h10);
            chk(v >= 16'h28 && v <= 16'h2A, 16'h1);
        end
        bus(1'h1, 6'h18, 8'h40);
        i_src.move(1'h0);
        wr16(6'h00, 16'h0001);
        wr16(6'h08, 16'h0010);
        bus(1'h1, 6'h18, 8'hC0);
        repeat (2) @(posedge clk);
        i_src.move(1'h1);
        {e0, t0} = {ev_n, tg_n};
        repeat (160) @(posedge clk);
        chk(ev_n - e0 >= 9 && ev_n - e0 <= 10, 16'h1);
        chk(tg_n - t0, ev_n - e0);
        bus(1'h0, 6'h00, 8'h0);
        bus(1'h0, 6'h04, 8'h0);
        v[7:0] = b;
        repeat (7) @(posedge clk);
        bus(1'h0, 6'h04, 8'h0);
        chk(b, v[7:0]);
        bus(1'h1, 6'h18, 8'h40);
        bus(1'h1, 6'h04, 8'h5A);
        bus(1'h0, 6'h04, 8'h0);
        chk(b, 16'h5A);
        bus(1'h1, 6'h00, 8'h12);
        rd16(6'h00);
        chk(v, 16'h125A);
        // Gated: active high input, restart after the first reload
        i_src.move(1'h0);
        bus(1'h1, 6'h18, 8'h00);
        wr16(6'h00, 16'h0030);
        wr16(6'h08, 16'h0038);
        bus(1'h1, 6'h18, 8'h80);
        repeat (10) @(posedge clk);
        rd16(6'h00);
        chk(v, 16'h0030);
        e0 = ev_n;
        i_src.move(1'h1);
        for (k = 0; k < 50 && ev_n == e0; k = k + 1) @(posedge clk);
        i_src.move(1'h0);
        repeat (4) @(posedge clk);
        rd16(6'h00);
        chk(v < 16'h10 && ev_n - e0 == 1, 16'h1);
        w = v;
        repeat (20) @(posedge clk);
        rd16(6'h00);
        chk(v, w);
        finish_test;
    end
endmodule

/* File: verilog/cctmr_edge_detect.v */
`timescale 1ns/100ps

// Detects the selected transition on the timer input
module cctmr_edge_detect (
    input wire clk,
    input wire rst,
    input wire din,
    input wire falling,
    output wire active_level,
    output wire active_edge
);

    reg prev_q;

    // Polarity turns the selected edge into a rising edge of active_level
    assign active_level = din ^ falling;
    assign active_edge = active_level && !(prev_q ^ falling);

    always @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= din;
        end
    end

endmodule

/* File: verilog/cctmr_prescaler.v */
`timescale 1ns/100ps

// Prescale by 2^sel; tick is a one-cycle enable, cleared while stopped
module cctmr_prescaler #(
    parameter SEL_W = 3
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [SEL_W-1:0] sel,
    output wire tick
);

    reg [127:0] div_q;
    wire [127:0] div_d;
    wire [127:0] mask;

    assign mask = (128'h1 << sel) - 128'h1;
    assign div_d = ((div_q & mask) == mask) ? 128'h0 : div_q + 128'h1;
    assign tick = run && ((div_q & mask) == mask);

    always @(posedge clk) begin
        if (rst || !run) begin
            div_q <= 128'h0;
        end else begin
            div_q <= div_d;
        end
    end

endmodule

/* File: verilog/cctmr_top.v */
`timescale 1ns/100ps
`include "cctmr_defines.vh"

module cctmr_top #(
    parameter CNT_W = 16,
    parameter PRESC_W = 3
) (
    input wire CLOCK,
    input wire RESET,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [5:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output wire WB_ACK_O,
    input wire TIMER_IN,
    output wire TIMER_OUT,
    output wire TIMER_EVENT
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_COUNT = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [CNT_W-1:0] count_q;
    reg [CNT_W-1:0] count_d;
    reg [CNT_W-1:0] reload_q;
    reg [CNT_W-1:0] capture_q;
    reg [7:0] hold_low_q;
    reg [7:0] control_q;
    reg out_q;
    reg event_q;
    reg event_flag_q;
    reg captured_flag_q;
    reg ack_q;

    wire enabled;
    wire mode_capture;
    wire tick;
    wire active_level;
    wire active_edge;
    wire bus_req;
    wire wr;
    wire rd;
    wire hit_reload;
    wire reload_event;
    wire capture_event;

    assign enabled = control_q[`CCTMR_CTL_ENABLE];
    assign mode_capture = control_q[`CCTMR_CTL_MODE];

    // ----------------------------------------
    // Wishbone slave, one wait state
    // ----------------------------------------
    // Ack is registered so read data comes from flip-flops in the ack cycle
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr = bus_req && WB_WE_I && WB_SEL_I[0];
    assign rd = bus_req && !WB_WE_I;
    assign WB_ACK_O = ack_q;

    always @(posedge CLOCK) begin
        if (RESET) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always @(posedge CLOCK) begin
        if (RESET) begin
            WB_DAT_O <= 32'h0;
        end else if (rd) begin
            case (WB_ADR_I)
                `CCTMR_ADR_CNT_HIGH: WB_DAT_O <= {24'h0, count_q[15:8]};
                `CCTMR_ADR_CNT_LOW: WB_DAT_O <= {24'h0, enabled ? hold_low_q : count_q[7:0]};
                `CCTMR_ADR_RLD_HIGH: WB_DAT_O <= {24'h0, reload_q[15:8]};
                `CCTMR_ADR_RLD_LOW: WB_DAT_O <= {24'h0, reload_q[7:0]};
                `CCTMR_ADR_CAP_HIGH: WB_DAT_O <= {24'h0, capture_q[15:8]};
                `CCTMR_ADR_CAP_LOW: WB_DAT_O <= {24'h0, capture_q[7:0]};
                `CCTMR_ADR_CONTROL: WB_DAT_O <= {24'h0, control_q};
                `CCTMR_ADR_STATUS: WB_DAT_O <= {29'h0, state_q == ST_COUNT, captured_flag_q, event_flag_q};
                default: WB_DAT_O <= 32'h0;
            endcase
        end
    end

    // Low byte snapshot; reads have no other side effect on counting
    always @(posedge CLOCK) begin
        if (RESET) begin
            hold_low_q <= 8'h00;
        end else if (rd && enabled && WB_ADR_I == `CCTMR_ADR_CNT_HIGH) begin
            hold_low_q <= count_q[7:0];
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge CLOCK) begin
        if (RESET) begin
            reload_q <= `CCTMR_RST_RELOAD;
            control_q <= `CCTMR_RST_CONTROL;
        end else if (wr) begin
            case (WB_ADR_I)
                `CCTMR_ADR_RLD_HIGH: reload_q[15:8] <= WB_DAT_I[7:0];
                `CCTMR_ADR_RLD_LOW: reload_q[7:0] <= WB_DAT_I[7:0];
                `CCTMR_ADR_CONTROL: control_q <= WB_DAT_I[7:0];
                default: control_q <= control_q;
            endcase
        end
    end

    // ----------------------------------------
    // Input edge and prescaler
    // ----------------------------------------
    cctmr_edge_detect u_edge (
        .clk(CLOCK),
        .rst(RESET),
        .din(TIMER_IN),
        .falling(control_q[`CCTMR_CTL_POLARITY]),
        .active_level(active_level),
        .active_edge(active_edge)
    );

    // Gated mode stops the prescaler too, so its phase is cleared to zero while gated off
    cctmr_prescaler #(
        .SEL_W(PRESC_W)
    ) u_presc (
        .clk(CLOCK),
        .rst(RESET),
        .run(state_q == ST_COUNT && enabled && (mode_capture || active_level)),
        .sel(control_q[`CCTMR_CTL_PRESC_HI:`CCTMR_CTL_PRESC_LO]),
        .tick(tick)
    );

    // ----------------------------------------
    // Counter control
    // ----------------------------------------
    assign hit_reload = tick && count_q == reload_q;
    // Enable gates both sources, so a disable write cannot let one last event slip out
    assign capture_event = state_q == ST_COUNT && enabled && mode_capture && active_edge;
    assign reload_event = hit_reload || capture_event;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enabled) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!enabled) begin
                    state_d = ST_IDLE;
                end else if (mode_capture ? active_edge : active_level) begin
                    state_d = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!enabled) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @* begin
        count_d = count_q;
        if (state_q == ST_COUNT && reload_event) begin
            count_d = `CCTMR_RESTART_COUNT;
        end else if (state_q == ST_COUNT && tick) begin
            count_d = count_q + 16'h0001;
        end
        // Direct writes have no holding register; each byte lands alone
        if (wr && WB_ADR_I == `CCTMR_ADR_CNT_HIGH) begin
            count_d[15:8] = WB_DAT_I[7:0];
        end
        if (wr && WB_ADR_I == `CCTMR_ADR_CNT_LOW) begin
            count_d[7:0] = WB_DAT_I[7:0];
        end
    end

    always @(posedge CLOCK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            count_q <= `CCTMR_RST_COUNT;
            capture_q <= `CCTMR_RST_CAPTURE;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            if (capture_event) begin
                capture_q <= count_q;
            end
        end
    end

    // ----------------------------------------
    // Output, event pulse and status
    // ----------------------------------------
    // Output level is preset from control while disabled so software picks the idle level
    always @(posedge CLOCK) begin
        if (RESET) begin
            out_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            event_q <= state_q == ST_COUNT && reload_event;
            if (!enabled) begin
                out_q <= control_q[`CCTMR_CTL_OUT_INIT];
            end else if (state_q == ST_COUNT && reload_event) begin
                out_q <= !out_q;
            end
        end
    end

    assign TIMER_OUT = out_q;
    assign TIMER_EVENT = event_q;

    // Sticky flags; a new event in the clearing cycle wins
    always @(posedge CLOCK) begin
        if (RESET) begin
            event_flag_q <= 1'b0;
            captured_flag_q <= 1'b0;
        end else begin
            if (state_q == ST_COUNT && reload_event) begin
                event_flag_q <= 1'b1;
            end else if (wr && WB_ADR_I == `CCTMR_ADR_STATUS && WB_DAT_I[`CCTMR_STS_EVENT]) begin
                event_flag_q <= 1'b0;
            end
            if (capture_event) begin
                captured_flag_q <= 1'b1;
            end else if (wr && WB_ADR_I == `CCTMR_ADR_STATUS && WB_DAT_I[`CCTMR_STS_CAPTURED]) begin
                captured_flag_q <= 1'b0;
            end
        end
    end

endmodule
